// file: msh_pkg.sv
/*
 * Constants for the motor startup and handoff configuration bank.
 * Assumes one synchronous clock domain and a plain register access port.
 */
package msh_pkg;

	// ----------------------------------------
	// Addresses
	// ----------------------------------------
	localparam int          ADDR_W              = 8;
	localparam logic [7:0]  ADDR_STARTUP_TWO    = 8'h84;
	localparam logic [7:0]  ADDR_CLOSED_ONE     = 8'h86;

	// ----------------------------------------
	// Startup register field layout
	// ----------------------------------------
	localparam int          ACCEL2_MSB          = 17;
	localparam int          ACCEL2_LSB          = 13;
	localparam int          XFER_MSB            = 12;
	localparam int          XFER_LSB            = 8;
	localparam int          AUTO_BIT            = 7;
	localparam int          FIRST_BIT           = 6;
	localparam int          DUTY_MSB            = 5;
	localparam int          DUTY_LSB            = 2;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [4:0]  ACCEL2_RST          = 5'h00;
	localparam logic [4:0]  XFER_RST            = 5'h00;
	localparam logic [3:0]  DUTY_RST            = 4'h0;
	localparam logic [31:0] CLOSED_ONE_RST      = 32'h0000_0000;
	localparam logic [4:0]  ACCEL2_NO_LIMIT     = 5'h1f;
	localparam logic [9:0]  XFER_HZ_RST         = 10'h001;
	localparam logic [8:0]  DUTY_PM_RST         = 9'h00f;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [4:0]  accel2;
		logic [4:0]  xfer_code;
		logic        auto_handoff;
		logic        first_zero;
		logic [3:0]  duty_code;
		logic [31:0] closed_one;
		logic [9:0]  xfer_hz;
		logic [8:0]  duty_pm;
		logic [31:0] rdata;
		logic        rvalid;
	} msh_state_t;

endpackage : msh_pkg

// file: msh_regs.sv
/*
 * Startup settings two and closed loop settings one registers, with decoded
 * handoff frequency and minimum duty for the startup sequencer.
 * Assumes synchronous access strobes from the configuration interface.
 */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Function
// ----------------------------------------
// Function
// - Five-bit second open-loop acceleration code at bits 17:13, reset zero, 1Fh unlimited.
// - Five-bit handoff frequency code at bits 12:8, reset zero, 1 to 600 Hz.
// - Bit 7 set hands off automatically; clear uses the handoff frequency field.
// - Bit 6 clear uses slow initial cycle rate; set starts first cycle at 0 Hz.
// - Four-bit minimum duty code at bits 5:2, 1.5 to 30 percent, reset zero.
// - Thirty-two bit closed loop settings register at 86h, resets to all zero.

module msh_regs (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	input  wire logic                     i_ce,
	// Register access
	input  wire logic                     i_wr_en,
	input  wire logic                     i_rd_en,
	input  wire logic [msh_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [31:0]              i_wdata,
	output logic      [31:0]              o_rdata,
	output logic                          o_rvalid,
	// Startup sequencer settings
	output logic      [4:0]               o_accel2_code,
	output logic                          o_accel2_no_limit,
	output logic      [4:0]               o_xfer_code,
	output logic      [9:0]               o_xfer_hz,
	output logic                          o_auto_handoff,
	output logic                          o_use_xfer_threshold,
	output logic                          o_first_zero_hz,
	output logic                          o_use_slow_initial_rate,
	output logic      [3:0]               o_duty_code,
	output logic      [8:0]               o_min_duty_permille,
	output logic      [31:0]              o_closed_one
);
	import msh_pkg::*;

	// ----------------------------------------
	// Decode tables
	// ----------------------------------------
	function automatic logic [9:0] xfer_hz_of(input logic [4:0] c);
		logic [9:0] hz;
		hz = 10'h000;
		if (c == 5'h00)
			hz = 10'h001;
		else if (c <= 5'h0a)
			hz = {3'h0, c, 2'h0};
		else if (c <= 5'h14)
			hz = 10'(10'd40 + 10'(c - 5'h0a) * 10'd5);
		else
			hz = 10'(10'd100 + 10'(c - 5'h15) * 10'd50);
		return hz;
	endfunction

	function automatic logic [8:0] duty_pm_of(input logic [3:0] c);
		logic [8:0] pm;
		pm = 9'h000;
		unique case (c)
			4'h0: pm = 9'd15;
			4'h1: pm = 9'd20;
			4'h2: pm = 9'd30;
			4'h3: pm = 9'd40;
			4'h4: pm = 9'd50;
			4'h5: pm = 9'd60;
			4'h6: pm = 9'd70;
			4'h7: pm = 9'd80;
			4'h8: pm = 9'd90;
			4'h9: pm = 9'd100;
			4'ha: pm = 9'd120;
			4'hb: pm = 9'd150;
			4'hc: pm = 9'd175;
			4'hd: pm = 9'd200;
			4'he: pm = 9'd250;
			4'hf: pm = 9'd300;
		endcase
		return pm;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	msh_state_t state_ff;
	msh_state_t nxt_state;
	logic       hit_startup;
	logic       hit_closed;
	logic [31:0] startup_view;

	assign hit_startup  = (i_addr == ADDR_STARTUP_TWO);
	assign hit_closed   = (i_addr == ADDR_CLOSED_ONE);
	assign startup_view = {14'h0, state_ff.accel2, state_ff.xfer_code,
		state_ff.auto_handoff, state_ff.first_zero, state_ff.duty_code,
		2'h0};

	always_comb begin
		nxt_state        = state_ff;
		nxt_state.rvalid = 1'b0;
		if (i_wr_en && hit_startup) begin
			nxt_state.accel2       = i_wdata[ACCEL2_MSB:ACCEL2_LSB];
			nxt_state.xfer_code    = i_wdata[XFER_MSB:XFER_LSB];
			nxt_state.auto_handoff = i_wdata[AUTO_BIT];
			nxt_state.first_zero   = i_wdata[FIRST_BIT];
			nxt_state.duty_code    = i_wdata[DUTY_MSB:DUTY_LSB];
		end
		if (i_wr_en && hit_closed) begin
			nxt_state.closed_one = i_wdata;
		end
		nxt_state.xfer_hz = xfer_hz_of(nxt_state.xfer_code);
		nxt_state.duty_pm = duty_pm_of(nxt_state.duty_code);
		if (i_rd_en) begin
			nxt_state.rvalid = 1'b1;
			if (hit_startup)
				nxt_state.rdata = startup_view;
			else if (hit_closed)
				nxt_state.rdata = state_ff.closed_one;
			else
				nxt_state.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_ff              <= '0;
			state_ff.accel2       <= ACCEL2_RST;
			state_ff.xfer_code    <= XFER_RST;
			state_ff.duty_code    <= DUTY_RST;
			state_ff.closed_one   <= CLOSED_ONE_RST;
			state_ff.xfer_hz      <= XFER_HZ_RST;
			state_ff.duty_pm      <= DUTY_PM_RST;
		end else if (i_ce) begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rdata                 = state_ff.rdata;
	assign o_rvalid                = state_ff.rvalid;
	assign o_accel2_code           = state_ff.accel2;
	assign o_accel2_no_limit       = (state_ff.accel2 == ACCEL2_NO_LIMIT);
	assign o_xfer_code             = state_ff.xfer_code;
	assign o_xfer_hz               = state_ff.xfer_hz;
	assign o_auto_handoff          = state_ff.auto_handoff;
	assign o_use_xfer_threshold    = ~state_ff.auto_handoff;
	assign o_first_zero_hz         = state_ff.first_zero;
	assign o_use_slow_initial_rate = ~state_ff.first_zero;
	assign o_duty_code             = state_ff.duty_code;
	assign o_min_duty_permille     = state_ff.duty_pm;
	assign o_closed_one            = state_ff.closed_one;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	accel2_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_startup |=> o_accel2_code == $past(i_wdata[17:13]))
		else $error("accel2 field not written");
	xfer_decode_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_xfer_code == 5'h1f |-> o_xfer_hz == 10'd600) and
		(o_xfer_code == 5'h00 |-> o_xfer_hz == 10'd1) and
		(o_xfer_code == 5'h0b |-> o_xfer_hz == 10'd45))
		else $error("handoff frequency decode wrong");
	auto_mode_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_startup ##1 1'b1 |->
		o_use_xfer_threshold == !$past(i_wdata[7]))
		else $error("handoff method wrong");
	first_cycle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_startup |=> o_first_zero_hz == $past(i_wdata[6]) &&
		o_first_zero_hz != o_use_slow_initial_rate)
		else $error("first cycle select wrong");
	duty_decode_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_duty_code == 4'h0 |-> o_min_duty_permille == 9'd15) and
		(o_duty_code == 4'hf |-> o_min_duty_permille == 9'd300) and
		(o_duty_code == 4'hc |-> o_min_duty_permille == 9'd175))
		else $error("minimum duty decode wrong");
	closed_reset_a: assert property (@(posedge i_clk)
		!i_rstn |=> o_closed_one == 32'h0000_0000 && o_xfer_code == 5'h00)
		else $error("reset value not zero");
	closed_rd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_rd_en && hit_closed && !i_wr_en |=> o_rvalid && o_rdata == o_closed_one)
		else $error("closed loop readback wrong");
	reserved_rd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_rd_en && hit_startup |=> o_rdata[1:0] == 2'h0 && o_rdata[31:18] == 14'h0)
		else $error("reserved bits not zero");
	freeze_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_rstn && !i_ce |=> $stable(o_closed_one) && $stable(o_duty_code) && $stable(o_rvalid))
		else $error("state moved while clock enable low");
	xfer_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_startup |=> o_xfer_code == $past(i_wdata[12:8]))
		else $error("handoff code not written");
	duty_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_startup |=> o_duty_code == $past(i_wdata[5:2]))
		else $error("duty code not written");
	closed_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_closed |=> o_closed_one == $past(i_wdata))
		else $error("closed loop register not written");
	other_rd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_rd_en && !hit_startup && !hit_closed |=> o_rvalid && o_rdata == 32'h0)
		else $error("unmapped read not zero");
	rvalid_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && !i_rd_en |=> !o_rvalid)
		else $error("read valid without read");
	rdata_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && !i_rd_en |=> $stable(o_rdata))
		else $error("read data moved without read");

	auto_cov_c:   cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_auto_handoff));
	nolimit_cov_c: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_accel2_no_limit));
	closed_cov_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
		i_ce && i_wr_en && hit_closed ##1 i_ce && i_rd_en && hit_closed);
	first_cov_c:  cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_first_zero_hz));
	duty_top_c:   cover property (@(posedge i_clk) disable iff (!i_rstn) o_duty_code == 4'hf);

endmodule : msh_regs

`default_nettype wire

// file: msh_regs_tb_top.sv
/*
 * Self-checking testbench for the startup and handoff settings bank.
 * Assumes msh_pkg and msh_regs are compiled first; one 50 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module msh_regs_tb_top;
	import msh_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        i_clk, i_rstn, i_ce, i_wr_en, i_rd_en;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, o_closed_one, w;
	logic        o_rvalid, o_no_lim, o_auto, o_thr, o_first, o_slow;
	logic [4:0]  o_accel2_code, o_xfer_code, a, x;
	logic [9:0]  o_xfer_hz;
	logic [3:0]  o_duty_code;
	logic [8:0]  o_min_duty_permille;
	int          n_mismatch, n_checks, cyc;
	int          dp[16] = '{15, 20, 30, 40, 50, 60, 70, 80, 90, 100, 120, 150, 175, 200, 250, 300};

	msh_regs dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .o_accel2_code(o_accel2_code), .o_accel2_no_limit(o_no_lim),
		.o_xfer_code(o_xfer_code), .o_xfer_hz(o_xfer_hz), .o_auto_handoff(o_auto),
		.o_use_xfer_threshold(o_thr), .o_first_zero_hz(o_first),
		.o_use_slow_initial_rate(o_slow), .o_duty_code(o_duty_code),
		.o_min_duty_permille(o_min_duty_permille), .o_closed_one(o_closed_one));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic int hz(input int c);
		if (c == 0) return 1;
		if (c <= 10) return 4 * c;
		if (c <= 20) return 45 + 5 * (c - 11);
		if (c == 21) return 100;
		return 150 + 50 * (c - 22);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge i_clk);
		i_wr_en <= 1'b1;
		i_addr  <= ad;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		@(posedge i_clk);
		i_rd_en <= 1'b1;
		i_addr  <= ad;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		#1;
		chk("rvalid", 1, o_rvalid);
		chk("rdata", e, o_rdata);
	endtask

	task automatic chk_rst();
		chk("accel2", 0, o_accel2_code);
		chk("xfer_hz", 1, o_xfer_hz);
		chk("auto", 0, {o_auto, o_thr ^ 1'b1});
		chk("first", 0, {o_first, o_slow ^ 1'b1});
		chk("duty", 15, o_min_duty_permille);
		chk("closed", 0, o_closed_one);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, reset, timeout
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{i_rstn, i_wr_en, i_rd_en, i_addr, i_wdata} = '0;
		i_ce = 1'b1;
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		chk_rst();
		rd(ADDR_STARTUP_TWO, 32'h0000_0000);
		rd(ADDR_CLOSED_ONE, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 32; i++) begin
			a = 5'(i);
			x = 5'(31 - i);
			w = {14'h3fff, a, x, a[0], a[1], a[3:0], 2'h3};
			wr(ADDR_STARTUP_TWO, w);
			chk("accel2", a, o_accel2_code);
			chk("no_limit", a == 5'h1f, o_no_lim);
			chk("xfer", x, o_xfer_code);
			chk("xfer_hz", hz(x), o_xfer_hz);
			chk("auto", {a[0], ~a[0]}, {o_auto, o_thr});
			chk("first", {a[1], ~a[1]}, {o_first, o_slow});
			chk("duty", a[3:0], o_duty_code);
			chk("duty_pm", dp[i % 16], o_min_duty_permille);
			rd(ADDR_STARTUP_TWO, {14'h0, w[17:2], 2'h0});
		end
		$display("test startup fields done");
		wr(ADDR_CLOSED_ONE, 32'ha5c3_0f96);
		chk("closed", 32'ha5c3_0f96, o_closed_one);
		@(posedge i_clk);
		i_rd_en <= 1'b1;
		i_wr_en <= 1'b1;
		i_wdata <= 32'h5a3c_f069;
		@(posedge i_clk);
		{i_rd_en, i_wr_en} <= 2'b00;
		#1;
		chk("rdata_old", 32'ha5c3_0f96, o_rdata);
		@(posedge i_clk);
		#1;
		chk("rvalid_end", 0, o_rvalid);
		wr(8'h85, 32'hffff_ffff);
		rd(ADDR_CLOSED_ONE, 32'h5a3c_f069);
		rd(8'h85, 32'h0000_0000);
		@(posedge i_clk);
		i_ce <= 1'b0;
		wr(ADDR_CLOSED_ONE, 32'h0000_0001);
		chk("ce_hold", 32'h5a3c_f069, o_closed_one);
		@(posedge i_clk);
		i_ce <= 1'b1;
		$display("test closed loop done");
		@(posedge i_clk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		chk_rst();
		$display("test second reset done");
		conclude();
	end

endmodule // msh_regs_tb_top

`default_nettype wire
